// File: verilog/dspr_pkg.sv
// constants and types of the dsp register file
package dspr_pkg;
  localparam int DSPR_BODY_W = 32;
  localparam int DSPR_GUARD_W = 8;
  localparam int DSPR_ACC_W = DSPR_BODY_W + DSPR_GUARD_W;
  localparam logic [31:0] DSPR_STATUS_RST = 32'h0000_0000;
  localparam int DSPR_BIT_GT = 7;
  localparam int DSPR_BIT_Z = 6;
  localparam int DSPR_BIT_N = 5;
  localparam int DSPR_BIT_V = 4;
  localparam int DSPR_SEL_HI = 3;
  localparam int DSPR_SEL_LO = 1;
  localparam int DSPR_BIT_DC = 0;
  localparam int DSPR_CIRC_SPLIT = 16;
  // dsp data register indices
  typedef enum logic [2:0] {
    DR_ACC0 = 3'b000, DR_ACC1 = 3'b001, DR_MUL0 = 3'b010, DR_MUL1 = 3'b011,
    DR_X0 = 3'b100, DR_X1 = 3'b101, DR_Y0 = 3'b110, DR_Y1 = 3'b111
  } dspr_dreg_t;
  // condition select codes
  typedef enum logic [2:0] {
    CS_CARRY = 3'b000, CS_NEG = 3'b001, CS_ZERO = 3'b010, CS_OVF = 3'b011,
    CS_GT = 3'b100, CS_GE = 3'b101
  } dspr_csel_t;
  // operation classes at write-back
  typedef enum logic [2:0] {
    OP_ALU = 3'b000, OP_PMUL = 3'b001, OP_PAIR_WORD_ADD_OP = 3'b010, OP_PAIR_WORD_SUB_OP = 3'b011,
    OP_XMOV = 3'b100, OP_YMOV = 3'b101, OP_SMOV = 3'b110, OP_NONE = 3'b111
  } dspr_op_t;
  // system register selectors
  typedef enum logic [3:0] {
    SR_STATUS = 4'b0000, SR_ACC0 = 4'b0001, SR_ACC1 = 4'b0010, SR_X0 = 4'b0011,
    SR_X1 = 4'b0100, SR_Y0 = 4'b0101, SR_Y1 = 4'b0110, SR_LBEG = 4'b0111,
    SR_LFIN = 4'b1000, SR_CIRC = 4'b1001
  } dspr_sreg_t;
  // address generator kinds
  typedef enum logic [1:0] {
    AG_X = 2'b00, AG_Y = 2'b01, AG_S = 2'b10
  } dspr_ag_t;
endpackage

// File: verilog/dspr_regs.sv
// dsp register file: data registers, status word, loop, circular bounds, banked general registers
`timescale 1ns/1ns
`default_nettype none
module dspr_regs
  import dspr_pkg::*;
#(
  parameter int GPR_COUNT = 16,
  parameter int BANKED = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wbValid,
  input wire dspr_op_t wbOp,
  input wire logic wbCond,
  input wire dspr_dreg_t wbDest,
  input wire logic [DSPR_ACC_W-1:0] wbData,
  input wire logic resCarry,
  input wire logic resNeg,
  input wire logic resZero,
  input wire logic resOvf,
  input wire dspr_dreg_t dRdSel,
  output logic [DSPR_ACC_W-1:0] dRdData_q,
  input wire logic sysWr,
  input wire dspr_sreg_t sysSel,
  input wire logic [31:0] sysWdata,
  output logic [31:0] sysRdata_q,
  output logic [31:0] statusWord_q,
  output logic dspCond_q,
  input wire logic privileged,
  input wire logic bankSelect,
  input wire logic [3:0] gprRdIdx,
  output logic [31:0] gprRdData_q,
  input wire logic gprWr,
  input wire logic [3:0] gprWrIdx,
  input wire logic [31:0] gprWdata,
  input wire logic [11:0] loopCount,
  input wire logic [31:0] fetchAddr,
  output logic loopBranch_q,
  output logic [31:0] loopTarget_q,
  input wire logic xCircEnable,
  input wire logic yCircEnable,
  input wire logic agValid,
  input wire dspr_ag_t agKind,
  input wire logic [3:0] agPtrIdx,
  input wire logic [3:0] agIdxIdx,
  output logic [31:0] agAddr_q,
  output logic agRefused_q
);
  initial begin
    if (GPR_COUNT != 16 || BANKED != 8) $error("dspr_regs serves 16 registers with 8 banked");
  end

  logic [DSPR_ACC_W-1:0] dReg_q [8];
  logic [DSPR_ACC_W-1:0] dReg_d [8];
  logic [31:0] status_q, status_d;
  logic [31:0] loopBeg_q, loopBeg_d, loopFin_q, loopFin_d, circ_q, circ_d;
  logic [31:0] gpr_q [24];
  logic [31:0] gpr_d [24];
  logic [DSPR_ACC_W-1:0] dRd_d;
  logic [31:0] sysRd_d, gprRd_d, loopTgt_d, agAddr_d;
  logic loopBr_d, agRef_d;

  // physical slot of a general register; 0..7 bank zero, 8..15 bank one, 16..23 unbanked
  function automatic logic [4:0] gprSlot(input logic [3:0] idx, input logic bank);
    if (idx[3]) return {2'b10, idx[2:0]};
    return {1'b0, bank, idx[2:0]};
  endfunction

  // condition picked by the select field
  function automatic logic condMet(input logic [2:0] sel, input logic c, input logic n,
                                   input logic z, input logic v);
    case (sel)
      CS_CARRY: return c;
      CS_NEG: return n;
      CS_ZERO: return z;
      CS_OVF: return v;
      CS_GT: return !n && !z;
      CS_GE: return !n;
      default: return 1'b0;
    endcase
  endfunction

  logic useBank;
  logic dspAllowed;
  logic flagUpd;
  assign useBank = privileged & bankSelect;
  assign dspAllowed = !wbCond || status_q[DSPR_BIT_DC];
  assign flagUpd = wbValid && !wbCond && (wbOp == OP_ALU);

  always_comb begin
    dReg_d = dReg_q;
    status_d = status_q;
    loopBeg_d = loopBeg_q;
    loopFin_d = loopFin_q;
    circ_d = circ_q;
    // system register writes
    if (sysWr) begin
      case (sysSel)
        SR_STATUS: status_d = {24'h00_0000, sysWdata[7:0]};
        SR_ACC0: dReg_d[DR_ACC0] = {{DSPR_GUARD_W{sysWdata[31]}}, sysWdata};
        SR_ACC1: dReg_d[DR_ACC1] = {{DSPR_GUARD_W{sysWdata[31]}}, sysWdata};
        SR_X0: dReg_d[DR_X0] = {8'h00, sysWdata};
        SR_X1: dReg_d[DR_X1] = {8'h00, sysWdata};
        SR_Y0: dReg_d[DR_Y0] = {8'h00, sysWdata};
        SR_Y1: dReg_d[DR_Y1] = {8'h00, sysWdata};
        SR_LBEG: loopBeg_d = sysWdata;
        SR_LFIN: loopFin_d = sysWdata;
        SR_CIRC: circ_d = sysWdata;
        default: ;
      endcase
    end
    // dsp write-back wins over a system write to the same register
    if (wbValid && dspAllowed) begin
      if (wbDest == DR_ACC0 || wbDest == DR_ACC1) begin
        dReg_d[wbDest] = wbData;
      end else begin
        dReg_d[wbDest] = {8'h00, wbData[DSPR_BODY_W-1:0]};
      end
    end
    // flags in the same cycle as the destination
    if (flagUpd) begin
      status_d[DSPR_BIT_GT] = !resNeg && !resZero;
      status_d[DSPR_BIT_Z] = resZero;
      status_d[DSPR_BIT_N] = resNeg;
      status_d[DSPR_BIT_V] = resOvf;
      status_d[DSPR_BIT_DC] = condMet(status_q[DSPR_SEL_HI:DSPR_SEL_LO], resCarry, resNeg,
                                      resZero, resOvf);
    end
    status_d[31:8] = 24'h00_0000;
  end

  // general registers with address generator write-back
  logic [4:0] agSlot, idxSlot;
  logic [31:0] agPtr, agNext, agStep;
  logic agOk, agWrap;
  always_comb begin
    gpr_d = gpr_q;
    agSlot = gprSlot(agPtrIdx, useBank);
    idxSlot = gprSlot(agIdxIdx, useBank);
    agPtr = gpr_q[agSlot];
    agStep = gpr_q[idxSlot];
    // pointer roles: x uses R4/R5 with R8, y uses R6/R7 with R9, single uses R2..R5 with R8
    case (agKind)
      AG_X: agOk = (agPtrIdx == 4'h4 || agPtrIdx == 4'h5) && agIdxIdx == 4'h8;
      AG_Y: agOk = (agPtrIdx == 4'h6 || agPtrIdx == 4'h7) && agIdxIdx == 4'h9;
      AG_S: agOk = agPtrIdx >= 4'h2 && agPtrIdx <= 4'h5 && agIdxIdx == 4'h8;
      default: agOk = 1'b0;
    endcase
    // at most one of the enables is set by software
    agWrap = ((agKind == AG_X && xCircEnable) || (agKind == AG_Y && yCircEnable))
             && agPtr[DSPR_CIRC_SPLIT-1:0] == circ_q[31:DSPR_CIRC_SPLIT];
    agNext = agWrap ? {agPtr[31:DSPR_CIRC_SPLIT], circ_q[DSPR_CIRC_SPLIT-1:0]} : agPtr + agStep;
    if (gprWr) begin
      gpr_d[gprSlot(gprWrIdx, useBank)] = gprWdata;
    end
    // address work proceeds regardless of the condition flag
    if (agValid && agOk) begin
      gpr_d[agSlot] = agNext;
    end
    agAddr_d = agValid && agOk ? agPtr : agAddr_q;
    agRef_d = agValid && !agOk;
  end

  // read ports and loop control
  always_comb begin
    dRd_d = dReg_q[dRdSel];
    gprRd_d = gpr_q[gprSlot(gprRdIdx, useBank)];
    case (sysSel)
      SR_STATUS: sysRd_d = {24'h00_0000, status_q[7:0]};
      SR_ACC0: sysRd_d = dReg_q[DR_ACC0][31:0];
      SR_ACC1: sysRd_d = dReg_q[DR_ACC1][31:0];
      SR_X0: sysRd_d = dReg_q[DR_X0][31:0];
      SR_X1: sysRd_d = dReg_q[DR_X1][31:0];
      SR_Y0: sysRd_d = dReg_q[DR_Y0][31:0];
      SR_Y1: sysRd_d = dReg_q[DR_Y1][31:0];
      SR_LBEG: sysRd_d = loopBeg_q;
      SR_LFIN: sysRd_d = loopFin_q;
      SR_CIRC: sysRd_d = circ_q;
      default: sysRd_d = 32'h0000_0000;
    endcase
    // branch back while more than one pass remains
    loopBr_d = fetchAddr == loopFin_q && loopCount > 12'h001;
    loopTgt_d = loopBeg_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        dReg_q[i] <= '0;
      end
      for (int i = 0; i < 24; i++) begin
        gpr_q[i] <= '0;
      end
      status_q <= DSPR_STATUS_RST;
      loopBeg_q <= '0;
      loopFin_q <= '0;
      circ_q <= '0;
      dRdData_q <= '0;
      sysRdata_q <= '0;
      gprRdData_q <= '0;
      statusWord_q <= DSPR_STATUS_RST;
      dspCond_q <= 1'b0;
      loopBranch_q <= 1'b0;
      loopTarget_q <= '0;
      agAddr_q <= '0;
      agRefused_q <= 1'b0;
    end else begin
      dReg_q <= dReg_d;
      gpr_q <= gpr_d;
      status_q <= status_d;
      loopBeg_q <= loopBeg_d;
      loopFin_q <= loopFin_d;
      circ_q <= circ_d;
      dRdData_q <= dRd_d;
      sysRdata_q <= sysRd_d;
      gprRdData_q <= gprRd_d;
      statusWord_q <= status_d;
      dspCond_q <= status_d[DSPR_BIT_DC];
      loopBranch_q <= loopBr_d;
      loopTarget_q <= loopTgt_d;
      agAddr_q <= agAddr_d;
      agRefused_q <= agRef_d;
    end
  end
endmodule
`default_nettype wire

// File: test/dspr_core_model.sv
// core-side partner supplying op1 minus op2 results with their status
`timescale 1ns/1ns
`default_nettype none
module dspr_core_model (
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  output logic [39:0] res,
  output logic c,
  output logic n,
  output logic z,
  output logic v
);
  logic [32:0] d;
  always_comb begin
    d = {1'b0, a} - {1'b0, b};
    res = {{8{d[31]}}, d[31:0]};
    c = d[32];
    n = d[31];
    z = d[31:0] == 32'h0000_0000;
    // overflow from sign mismatch; the raw sign in n ignores it on purpose
    v = (a[31] != b[31]) && (d[31] != a[31]);
  end
endmodule
`default_nettype wire

// File: test/dspr_chk_assertions.sv
// concurrent checks on the dsp register file ports
`timescale 1ns/1ns
`default_nettype none
module dspr_chk
  import dspr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wbValid,
  input wire dspr_op_t wbOp,
  input wire logic wbCond,
  input wire logic resNeg,
  input wire logic resZero,
  input wire logic resOvf,
  input wire logic sysWr,
  input wire dspr_sreg_t sysSel,
  input wire logic [31:0] sysWdata,
  input wire logic [31:0] statusWord_q,
  input wire logic dspCond_q,
  input wire logic agValid,
  input wire dspr_ag_t agKind,
  input wire logic [3:0] agPtrIdx,
  input wire logic [3:0] agIdxIdx,
  input wire logic agRefused_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic alu;
  assign alu = wbValid && wbOp == OP_ALU && !wbCond;
  rsvd_zero_a: assert property (statusWord_q[31:8] == 24'h00_0000)
    else $error("reserved status bits set");
  gt_flag_a: assert property (alu |=> statusWord_q[7] == (!$past(resNeg) && !$past(resZero)))
    else $error("greater flag wrong");
  zero_flag_a: assert property (alu |=> statusWord_q[6] == $past(resZero))
    else $error("zero flag wrong");
  neg_flag_a: assert property (alu |=> statusWord_q[5] == $past(resNeg))
    else $error("negative flag wrong");
  ovf_flag_a: assert property (alu |=> statusWord_q[4] == $past(resOvf))
    else $error("overflow flag wrong");
  dc_neg_a: assert property (alu && !sysWr && statusWord_q[3:1] == 3'h1 |=> dspCond_q == $past(resNeg))
    else $error("condition flag wrong");
  status_hold_a: assert property (wbValid && (wbCond || wbOp != OP_ALU) && !sysWr |=> $stable(statusWord_q))
    else $error("status changed");
  sys_write_a: assert property (sysWr && sysSel == SR_STATUS && !wbValid |=> statusWord_q[7:0] == $past(sysWdata[7:0]))
    else $error("status write lost");
  ag_refuse_a: assert property (agValid && agKind == AG_X && !(agPtrIdx inside {4'h4, 4'h5} && agIdxIdx == 4'h8)
    |=> agRefused_q)
    else $error("illegal pointer accepted");
endmodule
`default_nettype wire

// File: test/test_dspr_regs.sv
// self-checking bench for the dsp register file
`timescale 1ns/1ns
`default_nettype none
module test_dspr_regs import dspr_pkg::*;;
  logic core_clk = 0, rst_n, wbValid, wbCond, resCarry, resNeg, resZero, resOvf, sysWr, dspCond_q, privileged;
  logic bankSelect, gprWr, loopBranch_q, xCircEnable, yCircEnable, agValid, agRefused_q;
  dspr_op_t wbOp;
  dspr_dreg_t wbDest, dRdSel;
  dspr_sreg_t sysSel;
  dspr_ag_t agKind;
  logic [39:0] wbData, dRdData_q, ev[8];
  logic [31:0] sysWdata, sysRdata_q, statusWord_q, gprRdData_q, gprWdata, fetchAddr, loopTarget_q, agAddr_q, opA, opB;
  logic [3:0] gprRdIdx, gprWrIdx, agPtrIdx, agIdxIdx;
  logic [11:0] loopCount;
  logic [7:0] st;
  int n_fail = 0, comparisons = 0;
  dspr_regs dut (.*);
  dspr_core_model core (.a(opA), .b(opB), .res(wbData), .c(resCarry), .n(resNeg), .z(resZero), .v(resOvf));
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(logic [39:0] g, logic [39:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic dcf(logic [2:0] s, logic c, logic n, logic z, logic v);
    case (s)
      0: return c;
      1: return n;
      2: return z;
      3: return v;
      4: return !n && !z;
      5: return !n;
      default: return 0;
    endcase
  endfunction
  task automatic sys(dspr_sreg_t s, logic [31:0] w);
    // one idle edge first, so a back-to-back call never lowers and raises the strobe at once
    @(negedge core_clk);
    sysWr = 1;
    sysSel = s;
    sysWdata = w;
    if (s == SR_STATUS) st = w[7:0];
    @(negedge core_clk);
    sysWr = 0;
  endtask
  task automatic wb(dspr_op_t op, logic cnd, dspr_dreg_t d);
    wbOp = op;
    wbCond = cnd;
    wbDest = d;
    dRdSel = d;
    wbValid = 1;
    // guard byte survives only in the two accumulators
    if (!cnd || st[0]) ev[d] = d < 2 ? wbData : {8'h00, wbData[31:0]};
    if (op == OP_ALU && !cnd)
      st = {!resNeg && !resZero, resZero, resNeg, resOvf, st[3:1], dcf(st[3:1], resCarry, resNeg, resZero, resOvf)};
    @(negedge core_clk);
    wbValid = 0;
    chk(statusWord_q, st);
    chk(dspCond_q, st[0]);
    @(negedge core_clk);
    chk(dRdData_q, ev[d]);
  endtask
  task automatic gw(logic [3:0] i, logic [31:0] w);
    @(negedge core_clk);
    gprWr = 1;
    gprWrIdx = i;
    gprWdata = w;
    @(negedge core_clk);
    gprWr = 0;
  endtask
  task automatic gr(logic [3:0] i, logic [31:0] e);
    gprRdIdx = i;
    @(negedge core_clk);
    chk(gprRdData_q, e);
  endtask
  task automatic ag(dspr_ag_t k, logic [3:0] p, logic [31:0] e, logic r);
    agValid = 1;
    agKind = k;
    agPtrIdx = p;
    agIdxIdx = 4'h8;
    @(negedge core_clk);
    agValid = 0;
    chk(agRefused_q, r);
    if (!r) chk(agAddr_q, e);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {rst_n, wbValid, wbCond, sysWr, privileged, bankSelect, gprWr, xCircEnable, yCircEnable, agValid} = '0;
    {sysWdata, gprWdata, fetchAddr, opA, opB, gprRdIdx, gprWrIdx, agPtrIdx, agIdxIdx, loopCount} = '0;
    wbOp = OP_ALU;
    wbDest = DR_ACC0;
    dRdSel = DR_ACC0;
    sysSel = SR_STATUS;
    agKind = AG_X;
    ev = '{default: '0};
    st = 0;
    void'($urandom(75));
    repeat (6) @(negedge core_clk);
    rst_n = 1;
    chk(statusWord_q, 0);
    sys(SR_STATUS, 32'hFFFF_FF0B);
    chk(statusWord_q, 32'h0000_000B);
    for (int i = 0; i < 36; i++) begin
      opA = $urandom;
      opB = i % 3 ? $urandom : opA;
      sys(SR_STATUS, {24'h00_0000, 4'($urandom), 3'((i / 4) % 6), 1'($urandom)});
      wb(i % 2 ? dspr_op_t'(i % 4 == 1 ? 0 : i % 7) : dspr_op_t'(i % 7), i % 4 == 3, dspr_dreg_t'($urandom));
    end
    sysSel = SR_ACC0;
    @(negedge core_clk);
    chk(sysRdata_q, ev[0][31:0]);
    privileged = 1;
    bankSelect = 1;
    gw(4'h4, 32'h0001_0010);
    bankSelect = 0;
    gw(4'h4, 32'h5A5A_0000);
    gw(4'h8, 32'h0000_0002);
    bankSelect = 1;
    gr(4'h4, 32'h0001_0010);
    sys(SR_CIRC, 32'h0010_0004);
    @(negedge core_clk);
    chk(sysRdata_q, 32'h0010_0004);
    sys(SR_STATUS, 32'h0000_0000);
    xCircEnable = 1;
    ag(AG_X, 4'h4, 32'h0001_0010, 0);
    gr(4'h4, 32'h0001_0004);
    gw(4'h4, 32'h0001_0010);
    ag(AG_S, 4'h4, 32'h0001_0010, 0);
    gr(4'h4, 32'h0001_0012);
    ag(AG_X, 4'h6, 0, 1);
    sys(SR_LBEG, 32'h0000_0100);
    sys(SR_LFIN, 32'h0000_0120);
    fetchAddr = 32'h0000_0120;
    loopCount = 12'h002;
    repeat (2) @(negedge core_clk);
    chk(loopBranch_q, 1);
    chk(loopTarget_q, 32'h0000_0100);
    loopCount = 12'h001;
    repeat (2) @(negedge core_clk);
    chk(loopBranch_q, 0);
    conclude;
  end
  initial begin
    #20000;
    n_fail++;
    conclude;
  end
endmodule
bind dspr_regs dspr_chk chk (.*);
`default_nettype wire
